/* logic/dgp_pkg.sv */
// package for the dual gpio port block: offsets, reset values, carriers
package dgp_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] OFF_UP_PIN   = 8'h00;
    localparam logic [7:0] OFF_UP_LAT   = 8'h04;
    localparam logic [7:0] OFF_UP_DIR   = 8'h08;
    localparam logic [7:0] OFF_ANA_SEL  = 8'h0C;
    localparam logic [7:0] OFF_BC_PIN   = 8'h10;
    localparam logic [7:0] OFF_BC_LAT   = 8'h14;
    localparam logic [7:0] OFF_BC_DIR   = 8'h18;
    localparam logic [7:0] OFF_PU_CTRL  = 8'h1C;
    localparam logic [7:0] OFF_SYS_CTRL = 8'h20;
    localparam logic [7:0] OFF_DEFAULT  = 8'h0C;
    // field positions
    localparam int BIT_PU_EN      = 5;
    localparam int BIT_EXT_BUS_DIS = 7;
    localparam int BIT_SHARED_SEL = 4;
    localparam int BIT_PAR_REMAP  = 0;
    localparam int BIT_PWM_REMAP  = 1;
    localparam int BIT_SMALL_PKG  = 2;
    // reset values
    localparam logic [7:0] RST_LAT     = 8'h00;
    localparam logic [7:0] RST_DIR     = 8'hFF;
    localparam logic [7:0] RST_ANA_SEL = 8'hF0;
    localparam logic [7:0] RST_DEFAULT = 8'h00;
    localparam logic [7:0] RST_PU      = 8'h00;
    localparam logic [7:0] RST_SYS     = 8'h83;
    localparam logic [7:0] ANA_MASK    = 8'hF0;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // peripheral drive for one port: value and enable per pin
    typedef struct packed {
        logic [7:0] val;
        logic [7:0] en;
    } dgp_drive_t;
    // pwm channels routable onto the upper port
    typedef struct packed {
        logic p3c;
        logic p3b;
        logic p1c;
        logic p1b;
        logic [3:0] tri_st;
    } dgp_pwm_t;
endpackage : dgp_pkg

/* logic/dgp_top.sv */
// dual gpio port with memory bus, parallel port, pwm and analog overrides
`timescale 1ns/1ps
module dgp_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [3:0]  mem_high_address_bit,
    input  wire logic [7:0]  mem_ctrl_out,
    input  wire logic [7:0]  parallel_data_out,
    input  wire logic        parallel_data_oe,
    input  wire logic        parallel_byte_enable,
    input  wire logic        parallel_read_strobe,
    input  wire logic        parallel_write_strobe,
    input  wire dgp_pkg::dgp_pwm_t pwm_in,
    input  wire logic [7:0]  up_pin_in,
    output logic [7:0]       up_pin_out,
    output logic [7:0]       up_pin_oe_n,
    input  wire logic [7:0]  bc_pin_in,
    output logic [7:0]       bc_pin_out,
    output logic [7:0]       bc_pin_oe_n,
    output logic [7:0]       bc_pullup_on,
    output logic [3:0]       converter_input_channel,
    output logic [2:0]       parallel_data_in,
    output logic [7:0]       mem_data_unused
);
    // software registers
    logic [7:0] up_lat_r, up_dir_r, ana_sel_r, dflt_r;
    logic [7:0] bc_lat_r, bc_dir_r, pu_ctrl_r, sys_r;
    logic [7:0] up_s1_r, up_s2_r, bc_s1_r, bc_s2_r;
    logic       small_pkg, ext_bus_en, shared_sel, par_remap_n, pwm_remap_n;
    assign small_pkg   = sys_r[dgp_pkg::BIT_SMALL_PKG];
    assign ext_bus_en  = ~sys_r[dgp_pkg::BIT_EXT_BUS_DIS];
    assign shared_sel  = sys_r[dgp_pkg::BIT_SHARED_SEL];
    assign par_remap_n = ~sys_r[dgp_pkg::BIT_PAR_REMAP];
    assign pwm_remap_n = ~sys_r[dgp_pkg::BIT_PWM_REMAP];

    // two-flop synchronisers for the pad inputs; schmitt buffers are in the pad
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_s1_r <= 8'h00;
            up_s2_r <= 8'h00;
            bc_s1_r <= 8'h00;
            bc_s2_r <= 8'h00;
        end else begin
            up_s1_r <= up_pin_in;
            up_s2_r <= up_s1_r;
            bc_s1_r <= bc_pin_in;
            bc_s2_r <= bc_s1_r;
        end
    end

    // axi write channel: accept address and data in either order
    logic       aw_held_r, w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic       wr_go;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= dgp_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready;
            s_axi_wready  <= !w_held_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known(aw_addr_r) ? dgp_pkg::RESP_OKAY : dgp_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // address decode shared by read and write paths
    function automatic logic known(input logic [7:0] a);
        known = (a <= dgp_pkg::OFF_SYS_CTRL) && (a[1:0] == 2'b00);
    endfunction : known

    logic wr_lo;
    assign wr_lo = wr_go && w_strb_r[0];

    // register writes; direction holds only software values so overrides never land here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_lat_r  <= dgp_pkg::RST_LAT;
            up_dir_r  <= dgp_pkg::RST_DIR;
            ana_sel_r <= dgp_pkg::RST_ANA_SEL;
            dflt_r    <= dgp_pkg::RST_DEFAULT;
            bc_lat_r  <= dgp_pkg::RST_LAT;
            bc_dir_r  <= dgp_pkg::RST_DIR;
            pu_ctrl_r <= dgp_pkg::RST_PU;
            sys_r     <= dgp_pkg::RST_SYS;
        end else if (wr_lo) begin
            unique case (aw_addr_r)
                dgp_pkg::OFF_UP_PIN, dgp_pkg::OFF_UP_LAT: up_lat_r <= w_data_r[7:0];
                dgp_pkg::OFF_UP_DIR: up_dir_r <= w_data_r[7:0];
                dgp_pkg::OFF_ANA_SEL: begin
                    if (shared_sel) begin
                        ana_sel_r <= w_data_r[7:0] & dgp_pkg::ANA_MASK;
                    end else begin
                        dflt_r <= w_data_r[7:0];
                    end
                end
                dgp_pkg::OFF_BC_PIN, dgp_pkg::OFF_BC_LAT: bc_lat_r <= w_data_r[7:0];
                dgp_pkg::OFF_BC_DIR: bc_dir_r <= w_data_r[7:0];
                dgp_pkg::OFF_PU_CTRL: pu_ctrl_r <= w_data_r[7:0];
                dgp_pkg::OFF_SYS_CTRL: sys_r <= w_data_r[7:0];
                default: ;
            endcase
        end
    end

    // read mux; small package hides both ports and the pull-up enable
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            dgp_pkg::OFF_UP_PIN:   v = small_pkg ? 8'h00 : up_s2_r & ~ana_sel_r;
            dgp_pkg::OFF_UP_LAT:   v = small_pkg ? 8'h00 : up_lat_r;
            dgp_pkg::OFF_UP_DIR:   v = small_pkg ? 8'h00 : up_dir_r;
            dgp_pkg::OFF_ANA_SEL:  v = shared_sel ? ana_sel_r : dflt_r;
            dgp_pkg::OFF_BC_PIN:   v = small_pkg ? 8'h00 : bc_s2_r;
            dgp_pkg::OFF_BC_LAT:   v = small_pkg ? 8'h00 : bc_lat_r;
            dgp_pkg::OFF_BC_DIR:   v = small_pkg ? 8'h00 : bc_dir_r;
            dgp_pkg::OFF_PU_CTRL:  v = small_pkg ? (pu_ctrl_r & 8'hDF) : pu_ctrl_r;
            dgp_pkg::OFF_SYS_CTRL: v = sys_r;
            default:               v = 8'h00;
        endcase
        rd_mux = v;
    endfunction : rd_mux

    // axi read channel, one read at a time, data registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dgp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_mux(s_axi_araddr)};
                s_axi_rresp   <= known(s_axi_araddr) ? dgp_pkg::RESP_OKAY
                                                     : dgp_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // upper port pin mux: pwm > memory address > parallel > latch/direction
    logic [7:0] up_val, up_oe_n;
    logic [3:0] pwm_ch;
    assign pwm_ch = {pwm_in.p1b, pwm_in.p1c, pwm_in.p3b, pwm_in.p3c};
    always_comb begin
        up_val  = up_lat_r;
        up_oe_n = up_dir_r;
        if (par_remap_n) begin
            up_val[2] = parallel_data_out[7];
            up_oe_n[2] = ~parallel_data_oe;
            up_val[3] = parallel_data_out[6];
            up_oe_n[3] = ~parallel_data_oe;
            up_val[4] = parallel_data_out[3];
            up_oe_n[4] = ~parallel_data_oe;
            up_val[5] = parallel_byte_enable;
            up_oe_n[5] = 1'b0;
            up_val[6] = parallel_read_strobe;
            up_oe_n[6] = 1'b0;
            up_val[7] = parallel_write_strobe;
            up_oe_n[7] = 1'b0;
        end
        if (ext_bus_en) begin
            up_val[3:0]  = mem_high_address_bit;
            up_oe_n[3:0] = 4'h0;
        end
        // pwm wins only where its pin's direction is output
        for (int i = 0; i < 4; i++) begin
            if (pwm_remap_n && !up_dir_r[4+i]) begin
                up_val[4+i]  = pwm_ch[i];
                up_oe_n[4+i] = pwm_in.tri_st[i];
            end
        end
    end

    // bus-control pin mux and pull-up gating
    logic [7:0] bc_val, bc_oe_n, pu_nxt;
    always_comb begin
        bc_val  = ext_bus_en ? mem_ctrl_out : bc_lat_r;
        bc_oe_n = ext_bus_en ? 8'h00 : bc_dir_r;
        pu_nxt  = (pu_ctrl_r[dgp_pkg::BIT_PU_EN] && !small_pkg) ? bc_oe_n : 8'h00;
    end

    // pad outputs registered so every top output comes from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_pin_out              <= 8'h00;
            up_pin_oe_n             <= 8'hFF;
            bc_pin_out              <= 8'h00;
            bc_pin_oe_n             <= 8'hFF;
            bc_pullup_on            <= 8'h00;
            converter_input_channel <= 4'hF;
            parallel_data_in        <= 3'h0;
            mem_data_unused         <= 8'h00;
        end else begin
            up_pin_out              <= up_val;
            up_pin_oe_n             <= up_oe_n;
            bc_pin_out              <= bc_val;
            bc_pin_oe_n             <= bc_oe_n;
            bc_pullup_on            <= pu_nxt;
            converter_input_channel <= ana_sel_r[7:4];
            parallel_data_in        <= {up_s2_r[2], up_s2_r[3], up_s2_r[4]};
            mem_data_unused         <= bc_s2_r;
        end
    end
endmodule : dgp_top

/* sim/dgp_monitor.sv */
// port-level checker for the dual gpio port block
`timescale 1ns/1ps
module dgp_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  up_pin_oe_n,
    input wire logic [7:0]  bc_pin_oe_n,
    input wire logic [7:0]  bc_pullup_on,
    input wire logic [3:0]  converter_input_channel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // reset check is not disabled by reset, it watches the reset itself
    AST_RST_PINS: assert property (disable iff (1'b0) !aresetn |=> bc_pin_oe_n == 8'hFF
        && up_pin_oe_n == 8'hFF && bc_pullup_on == 8'h00 && converter_input_channel == 4'hF
        && !s_axi_bvalid && !s_axi_rvalid) else $error("pins not idle after reset");
    AST_PU_OUT: assert property ((bc_pullup_on & ~bc_pin_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_PU_ALL: assert property (bc_pullup_on == 8'h00 || bc_pullup_on == bc_pin_oe_n)
        else $error("pull-ups not switched together");
    // bus answers stand until taken
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000
        && (s_axi_rresp == 2'b00 || s_axi_rresp == 2'b10)) else $error("bad read word");
endmodule : dgp_monitor

bind dgp_top dgp_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .up_pin_oe_n(up_pin_oe_n), .bc_pin_oe_n(bc_pin_oe_n),
    .bc_pullup_on(bc_pullup_on), .converter_input_channel(converter_input_channel));

/* sim/dgp_top_tb_top.sv */
// self-checking testbench for the dual gpio port block
`timescale 1ns/1ps
module dgp_top_tb_top;
    logic              aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]        awaddr = 8'h00, araddr = 8'h00, mctl = 8'h00, pdo = 8'h00;
    logic [7:0]        upi = 8'h00, bci = 8'h00;
    logic [31:0]       wdata = 32'h0000_0000;
    logic [3:0]        mha = 4'h0;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic              rready = 1'b0, pdoe = 1'b0, pbe = 1'b0, prd = 1'b0, pwr = 1'b0;
    dgp_pkg::dgp_pwm_t pwm = 8'h00;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic [7:0]        upo, upoe, bco, bcoe, bcpu;
    logic [3:0]        conv;
    logic [2:0]        pdi;
    int                num_errors = 0, tests_run = 0;

    always #2.5 aclk = ~aclk;

    dgp_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mem_high_address_bit(mha), .mem_ctrl_out(mctl), .parallel_data_out(pdo),
        .parallel_data_oe(pdoe), .parallel_byte_enable(pbe), .parallel_read_strobe(prd),
        .parallel_write_strobe(pwr), .pwm_in(pwm), .up_pin_in(upi), .up_pin_out(upo),
        .up_pin_oe_n(upoe), .bc_pin_in(bci), .bc_pin_out(bco), .bc_pin_oe_n(bcoe),
        .bc_pullup_on(bcpu), .converter_input_channel(conv), .parallel_data_in(pdi),
        .mem_data_unused());

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            aw_d = aw_d | (awready === 1'b1);
            w_d = w_d | (wready === 1'b1);
            awvalid <= !aw_d;
            wvalid <= !w_d;
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        chk("bresp", er, bresp);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    // read: rready raised a cycle late so the slave must hold its answer
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
        chk("rresp", er, rresp);
        if (er === dgp_pkg::RESP_OKAY) chk("rdata", e, rdata);
        @(posedge aclk);
    endtask : rd

    task automatic t_reset;
        chk("bc_oe_n", 8'hFF, bcoe);
        chk("bc_pullup", 8'h00, bcpu);
        chk("conv", 4'hF, conv);
        rd(dgp_pkg::OFF_UP_DIR, dgp_pkg::RST_DIR, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_BC_DIR, 8'hFF, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_PU_CTRL, 8'h00, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_SYS_CTRL, dgp_pkg::RST_SYS, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_ANA_SEL, dgp_pkg::RST_DEFAULT, dgp_pkg::RESP_OKAY);
        rd(8'h24, 8'h00, dgp_pkg::RESP_SLVERR);
        wr(8'h02, 8'hFF, dgp_pkg::RESP_SLVERR);
    endtask : t_reset

    task automatic t_upper;
        wr(dgp_pkg::OFF_UP_PIN, 8'hA5, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_UP_LAT, 8'hA5, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_UP_DIR, 8'h0F, dgp_pkg::RESP_OKAY);
        upi <= 8'h3C;
        repeat (3) @(posedge aclk);
        chk("up_oe_n", 8'h0F, upoe);
        chk("up_out", 4'hA, upo[7:4]);
        rd(dgp_pkg::OFF_UP_PIN, 8'h0C, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_SYS_CTRL, 8'h93, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_ANA_SEL, 8'h0F, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_ANA_SEL, 8'h00, dgp_pkg::RESP_OKAY);
        chk("conv", 4'h0, conv);
        rd(dgp_pkg::OFF_UP_PIN, 8'h3C, dgp_pkg::RESP_OKAY);
    endtask : t_upper

    task automatic t_mem;
        mha <= 4'h9;
        mctl <= 8'h5A;
        wr(dgp_pkg::OFF_SYS_CTRL, 8'h03, dgp_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("up_out", 4'h9, upo[3:0]);
        chk("up_oe_n", 4'h0, upoe[3:0]);
        chk("bc_out", 8'h5A, bco);
        chk("bc_oe_n", 8'h00, bcoe);
        rd(dgp_pkg::OFF_BC_DIR, 8'hFF, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_UP_DIR, 8'h0F, dgp_pkg::RESP_OKAY);
    endtask : t_mem

    task automatic t_pull;
        bci <= 8'hA5;
        wr(dgp_pkg::OFF_SYS_CTRL, 8'h83, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_PU_CTRL, 8'h20, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_BC_DIR, 8'hF0, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_BC_LAT, 8'h0C, dgp_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("bc_pullup", 8'hF0, bcpu);
        chk("bc_out", 4'hC, bco[3:0]);
        rd(dgp_pkg::OFF_BC_PIN, 8'hA5, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_PU_CTRL, 8'h00, dgp_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("bc_pullup", 8'h00, bcpu);
    endtask : t_pull

    // pwm wins over parallel strobes only on pins whose direction is 0
    task automatic t_pwm;
        pwm <= 8'hA0;
        pdo <= 8'hC8;
        pdoe <= 1'b1;
        pbe <= 1'b1;
        pwr <= 1'b1;
        upi <= 8'h1C;
        wr(dgp_pkg::OFF_SYS_CTRL, 8'h80, dgp_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("up_out", 6'h17, upo[7:2]);
        chk("up_oe_n", 8'h03, upoe);
        chk("par_in", 3'h7, pdi);
        pwm.tri_st <= 4'h1;
        repeat (3) @(posedge aclk);
        chk("up_oe_n", 8'h13, upoe);
        wr(dgp_pkg::OFF_UP_DIR, 8'hFF, dgp_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("up_out", 6'h2F, upo[7:2]);
        wr(dgp_pkg::OFF_UP_DIR, 8'h0F, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_SYS_CTRL, 8'h82, dgp_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("up_out", 4'hB, upo[7:4]);
    endtask : t_pwm

    // small package hides both ports and gates the shared pull-up enable
    task automatic t_small;
        wr(dgp_pkg::OFF_PU_CTRL, 8'h20, dgp_pkg::RESP_OKAY);
        wr(dgp_pkg::OFF_SYS_CTRL, 8'h86, dgp_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("bc_pullup", 8'h00, bcpu);
        rd(dgp_pkg::OFF_UP_LAT, 8'h00, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_BC_PIN, 8'h00, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_PU_CTRL, 8'h00, dgp_pkg::RESP_OKAY);
        rd(dgp_pkg::OFF_SYS_CTRL, 8'h86, dgp_pkg::RESP_OKAY);
    endtask : t_small

    task automatic results;
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // main sequence after an eight-cycle reset
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_upper();
        t_mem();
        t_pull();
        t_pwm();
        t_small();
        results();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule : dgp_top_tb_top
